/* File: include/adc_ref_select_defines.vh */
`ifndef ADC_REF_SELECT_DEFINES_VH
`define ADC_REF_SELECT_DEFINES_VH
// Register offsets on the plain register port.
`define ADDR_AMP_REF_CONTROL 4'h0
`define ADDR_BANDGAP_CONTROL 4'h1
`define ADDR_ADC_CONTROL_FIRST 4'h2
`define ADDR_ADC_CONTROL_SECOND 4'h3
`define ADDR_PIN_FUNCTION_SELECT 4'h4
`define ADDR_PIN_PULLUP 4'h5
`define ADDR_PIN_DIRECTION 4'h6
`define ADDR_PIN_OUTPUT 4'h7
`define ADDR_ANALOG_STATUS 4'h8
// Field positions in the amplifier and reference control register.
`define AMP_ENABLE_BIT 7
`define AMP_INPUT_SOURCE_BIT 4
`define REF_SOURCE_HI 3
`define REF_SOURCE_LO 2
`define AMP_GAIN_HI 1
`define AMP_GAIN_LO 0
`define AMP_REF_WRITE_MASK 8'h9F
// Bandgap control register.
`define BANDGAP_ENABLE_BIT 0
`define BANDGAP_WRITE_MASK 8'h01
// Input source field in the second control register, channel field in the first.
`define INPUT_SOURCE_HI 7
`define INPUT_SOURCE_LO 4
`define CHANNEL_HI 3
`define CHANNEL_LO 0
// Reset values.
`define AMP_REF_RESET 8'h00
`define BANDGAP_RESET 8'h00
`define CONTROL_RESET 8'h00
`define PIN_REG_RESET 16'h0000
// Internal signal select codes, binary-coded on the converter mux.
`define INT_SEL_SUPPLY 3'h1
`define INT_SEL_SUPPLY_HALF 3'h2
`define INT_SEL_SUPPLY_QUARTER 3'h3
`define INT_SEL_AMP 3'h4
`define INT_SEL_AMP_HALF 3'h5
`define INT_SEL_AMP_QUARTER 3'h6
`define INT_SEL_GROUND 3'h7
`define INT_SEL_NONE 3'h0
`endif

/* File: rtl/input_source_decode.v */
`timescale 1ns/100ps
`default_nettype none
`include "adc_ref_select_defines.vh"
// Decodes the input source and channel fields into the converter input selects.
module input_source_decode (
	input wire [3:0] input_source, // Input source field.
	input wire [3:0] channel, // External channel field.
	output reg [15:0] channel_onehot, // External channel switch enables.
	output reg [2:0] internal_sel // Internal signal select code, zero when external.
);
	// External sources never share the node with an internal one.
	always @* begin
		channel_onehot = 16'h0000;
		internal_sel = `INT_SEL_NONE;
		case (input_source)
			4'h1: internal_sel = `INT_SEL_SUPPLY;
			4'h2: internal_sel = `INT_SEL_SUPPLY_HALF;
			4'h3: internal_sel = `INT_SEL_SUPPLY_QUARTER;
			4'h5: internal_sel = `INT_SEL_AMP;
			4'h6: internal_sel = `INT_SEL_AMP_HALF;
			4'h7: internal_sel = `INT_SEL_AMP_QUARTER;
			4'h8, 4'h9, 4'hA, 4'hB: internal_sel = `INT_SEL_GROUND;
			default: channel_onehot = 16'h0001 << channel;
		endcase
	end
endmodule
`default_nettype wire

/* File: rtl/pin_function_override.v */
`timescale 1ns/100ps
`default_nettype none
// Forces pins that serve as analog inputs off their digital functions.
module pin_function_override #(
	parameter PINS = 16 // Number of shared pins.
) (
	input wire [PINS-1:0] analog_mode, // Pin selected as analog input.
	input wire [PINS-1:0] pullup_in, // Programmed pull-ups.
	input wire [PINS-1:0] dir_in, // Programmed direction, one is output.
	output wire [PINS-1:0] pullup_out, // Effective pull-ups.
	output wire [PINS-1:0] dir_out, // Effective output enables.
	output wire [PINS-1:0] digital_en // Digital function still attached.
);
	// An analog pin loses pull-up, driver and digital function together.
	assign pullup_out = pullup_in & ~analog_mode;
	assign dir_out = dir_in & ~analog_mode;
	assign digital_en = ~analog_mode;
endmodule
`default_nettype wire

/* File: rtl/adc_ref_input_select.v */
`timescale 1ns/100ps
`default_nettype none
`include "adc_ref_select_defines.vh"
module adc_ref_input_select (
	input wire core_clk, // System clock, 25 MHz.
	input wire srst, // Synchronous reset, active high.
	input wire [3:0] addr, // Register address.
	input wire [15:0] wdata, // Write data.
	input wire wr_stb, // Write strobe.
	input wire rd_stb, // Read strobe.
	output reg [15:0] rdata, // Read data, valid the cycle after the strobe.
	output reg amp_power_en, // Reference amplifier power.
	output reg amp_in_pin_sw, // Reference input pin to amplifier switch.
	output reg amp_in_bandgap_sw, // Bandgap voltage to amplifier switch.
	output reg [1:0] amp_gain, // Amplifier gain code.
	output reg ref_supply_sw, // Converter supply as reference.
	output reg ref_pin_sw, // External reference pin as reference.
	output reg ref_amp_sw, // Amplifier output as reference.
	output reg bandgap_power_en, // Bandgap circuit power.
	output reg [15:0] channel_sw, // External channel switches.
	output reg [2:0] internal_sel, // Internal input select, zero when external.
	output reg [15:0] pin_pullup_en, // Effective pull-up enables.
	output reg [15:0] pin_drive_en, // Effective output drivers.
	output reg [15:0] pin_digital_en // Digital function attached.
);
	////////////////////////////////////////////////////////////////////////
	// Software registers.
	reg [7:0] amp_ref_control_reg;
	reg [7:0] bandgap_control_reg;
	reg [7:0] adc_control_first_reg;
	reg [7:0] adc_control_second_reg;
	reg [15:0] pin_analog_reg;
	reg [15:0] pin_pullup_reg;
	reg [15:0] pin_dir_reg;
	reg [15:0] rdata_next;
	wire [15:0] chan_onehot;
	wire [2:0] int_sel;
	wire [15:0] pullup_eff;
	wire [15:0] dir_eff;
	wire [15:0] digital_eff;

	// Masks keep unused positions of the amplifier and bandgap registers at zero so reads return zero there.
	// unimplemented bits zero
	always @(posedge core_clk) begin
		if (srst) begin
			amp_ref_control_reg <= `AMP_REF_RESET;
			bandgap_control_reg <= `BANDGAP_RESET;
			adc_control_first_reg <= `CONTROL_RESET;
			adc_control_second_reg <= `CONTROL_RESET;
			pin_analog_reg <= `PIN_REG_RESET;
			pin_pullup_reg <= `PIN_REG_RESET;
			pin_dir_reg <= `PIN_REG_RESET;
		end else if (wr_stb) begin
			case (addr)
				`ADDR_AMP_REF_CONTROL: begin
					amp_ref_control_reg <= wdata[7:0] & `AMP_REF_WRITE_MASK;
				end
				`ADDR_BANDGAP_CONTROL: begin
					bandgap_control_reg <= wdata[7:0] & `BANDGAP_WRITE_MASK;
				end
				`ADDR_ADC_CONTROL_FIRST: begin
					adc_control_first_reg <= wdata[7:0];
				end
				`ADDR_ADC_CONTROL_SECOND: begin
					adc_control_second_reg <= wdata[7:0];
				end
				`ADDR_PIN_FUNCTION_SELECT: begin
					pin_analog_reg <= wdata;
				end
				`ADDR_PIN_PULLUP: begin
					pin_pullup_reg <= wdata;
				end
				`ADDR_PIN_DIRECTION: begin
					pin_dir_reg <= wdata;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path; unmapped addresses read zero.
	always @* begin
		rdata_next = 16'h0000;
		case (addr)
			`ADDR_AMP_REF_CONTROL: rdata_next = {8'h00, amp_ref_control_reg};
			`ADDR_BANDGAP_CONTROL: rdata_next = {8'h00, bandgap_control_reg};
			`ADDR_ADC_CONTROL_FIRST: rdata_next = {8'h00, adc_control_first_reg};
			`ADDR_ADC_CONTROL_SECOND: rdata_next = {8'h00, adc_control_second_reg};
			`ADDR_PIN_FUNCTION_SELECT: rdata_next = pin_analog_reg;
			`ADDR_PIN_PULLUP: rdata_next = pin_pullup_reg;
			`ADDR_PIN_DIRECTION: rdata_next = pin_dir_reg;
			`ADDR_PIN_OUTPUT: rdata_next = pin_drive_en;
			`ADDR_ANALOG_STATUS: rdata_next = {10'h000, internal_sel, ref_amp_sw,
				amp_in_bandgap_sw, amp_power_en};
			default: rdata_next = 16'h0000;
		endcase
	end

	// Data stand only in the cycle after the read strobe.
	always @(posedge core_clk) begin
		if (srst) begin
			rdata <= 16'h0000;
		end else if (rd_stb) begin
			rdata <= rdata_next;
		end else begin
			rdata <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Converter input decoding.
	// external channel codes
	input_source_decode u_decode (
		.input_source(adc_control_second_reg[`INPUT_SOURCE_HI:`INPUT_SOURCE_LO]),
		.channel(adc_control_first_reg[`CHANNEL_HI:`CHANNEL_LO]),
		.channel_onehot(chan_onehot),
		.internal_sel(int_sel)
	);

	// Pin overrides for analog-selected pins.
	// digital function removed
	pin_function_override #(
		.PINS(16)
	) u_override (
		.analog_mode(pin_analog_reg),
		.pullup_in(pin_pullup_reg),
		.dir_in(pin_dir_reg),
		.pullup_out(pullup_eff),
		.dir_out(dir_eff),
		.digital_en(digital_eff)
	);

	////////////////////////////////////////////////////////////////////////
	// Registered analog controls, updated on the edge after the register write.
	// The one-cycle lag keeps decode glitches off the analog switches.
	// registered analog outputs
	always @(posedge core_clk) begin
		if (srst) begin
			amp_power_en <= 1'b0;
			amp_in_pin_sw <= 1'b0;
			amp_in_bandgap_sw <= 1'b0;
			amp_gain <= 2'h0;
			ref_supply_sw <= 1'b0;
			ref_pin_sw <= 1'b0;
			ref_amp_sw <= 1'b0;
			bandgap_power_en <= 1'b0;
			channel_sw <= 16'h0000;
			internal_sel <= 3'h0;
			pin_pullup_en <= 16'h0000;
			pin_drive_en <= 16'h0000;
			pin_digital_en <= 16'h0000;
		end else begin
			amp_power_en <= amp_ref_control_reg[`AMP_ENABLE_BIT];
			amp_in_bandgap_sw <= amp_ref_control_reg[`AMP_INPUT_SOURCE_BIT];
			amp_in_pin_sw <= ~amp_ref_control_reg[`AMP_INPUT_SOURCE_BIT];
			amp_gain <= amp_ref_control_reg[`AMP_GAIN_HI:`AMP_GAIN_LO];
			ref_amp_sw <= amp_ref_control_reg[`REF_SOURCE_HI];
			ref_supply_sw <= (amp_ref_control_reg[`REF_SOURCE_HI:`REF_SOURCE_LO] == 2'h0);
			// external pin only for code 01
			ref_pin_sw <= (amp_ref_control_reg[`REF_SOURCE_HI:`REF_SOURCE_LO] == 2'h1);
			bandgap_power_en <= bandgap_control_reg[`BANDGAP_ENABLE_BIT];
			channel_sw <= chan_onehot;
			internal_sel <= int_sel;
			pin_pullup_en <= pullup_eff;
			pin_drive_en <= dir_eff;
			pin_digital_en <= digital_eff;
		end
	end
endmodule
`default_nettype wire

/* File: tb/adc_ref_input_select_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches the register port and the analog controls of the selector, all but ref_supply_sw.
module adc_sel_chk (
	input wire logic core_clk, // Clock.
	input wire logic srst, // Reset.
	input wire logic [3:0] addr, // Address.
	input wire logic [15:0] wdata, // Write data.
	input wire logic wr_stb, // Write strobe.
	input wire logic rd_stb, // Read strobe.
	input wire logic [15:0] rdata, // Read data.
	input wire logic amp_power_en, // Amp power.
	input wire logic amp_in_pin_sw, // Pin to amp.
	input wire logic amp_in_bandgap_sw, // Bandgap to amp.
	input wire logic [1:0] amp_gain, // Gain.
	input wire logic ref_pin_sw, // Pin reference.
	input wire logic ref_amp_sw, // Amp reference.
	input wire logic bandgap_power_en, // Bandgap power.
	input wire logic [15:0] channel_sw, // Channels.
	input wire logic [2:0] internal_sel, // Internal select.
	input wire logic [15:0] pin_pullup_en, // Pull-ups.
	input wire logic [15:0] pin_drive_en, // Drivers.
	input wire logic [15:0] pin_digital_en // Digital attach.
);
	// Controls land one edge after the write that sets them and are checked at the second edge.
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_amp;
		wr_stb && addr == 4'h0 |-> ##2 amp_power_en == $past(wdata[7], 2);
	endproperty
	a_amp: assert property (p_amp) else $error("amp power wrong");
	property p_src;
		wr_stb && addr == 4'h0 |-> ##2 amp_in_bandgap_sw == $past(wdata[4], 2)
			&& amp_in_pin_sw != amp_in_bandgap_sw;
	endproperty
	a_src: assert property (p_src) else $error("amp source wrong");
	property p_ref;
		wr_stb && addr == 4'h0 |-> ##2 ref_amp_sw == $past(wdata[3], 2)
			&& ref_pin_sw == ($past(wdata[3:2], 2) == 2'h1);
	endproperty
	a_ref: assert property (p_ref) else $error("reference wrong");
	property p_gain;
		wr_stb && addr == 4'h0 |-> ##2 amp_gain == $past(wdata[1:0], 2);
	endproperty
	a_gain: assert property (p_gain) else $error("gain wrong");
	property p_bg;
		wr_stb && addr == 4'h1 |-> ##2 bandgap_power_en == $past(wdata[0], 2);
	endproperty
	a_bg: assert property (p_bg) else $error("bandgap power wrong");
	property p_mask;
		rd_stb && addr[3:1] == 3'h0 |=> rdata[15:8] == 8'h00 && rdata[6:5] == 2'h0
			&& (!$past(addr[0]) || rdata[7:1] == 7'h00);
	endproperty
	a_mask: assert property (p_mask) else $error("loose bits read high");
	property p_iso;
		internal_sel != 3'h0 |-> channel_sw == 16'h0000;
	endproperty
	a_iso: assert property (p_iso) else $error("channel left on");
	property p_one;
		channel_sw != 16'h0000 |-> $onehot(channel_sw) && internal_sel == 3'h0;
	endproperty
	a_one: assert property (p_one) else $error("channel not one-hot");
	property p_dig;
		wr_stb && addr == 4'h4 |-> ##2 pin_digital_en == ~$past(wdata, 2);
	endproperty
	a_dig: assert property (p_dig) else $error("digital attach wrong");
	property p_pin;
		((pin_pullup_en | pin_drive_en) & ~pin_digital_en) == 16'h0000;
	endproperty
	a_pin: assert property (p_pin) else $error("analog pin driven");
endmodule
bind adc_ref_input_select adc_sel_chk adc_sel_chk_inst (.core_clk, .srst, .addr, .wdata,
	.wr_stb, .rd_stb, .rdata, .amp_power_en, .amp_in_pin_sw, .amp_in_bandgap_sw, .amp_gain,
	.ref_pin_sw, .ref_amp_sw, .bandgap_power_en, .channel_sw, .internal_sel, .pin_pullup_en,
	.pin_drive_en, .pin_digital_en);
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic core_clk = 0, srst = 1, wr_stb = 0, rd_stb = 0, rd_d = 0, look_stb = 0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata, r1, r2, r3;
	logic amp_power_en, amp_in_pin_sw, amp_in_bandgap_sw, ref_supply_sw, ref_pin_sw;
	logic ref_amp_sw, bandgap_power_en;
	logic [1:0] amp_gain;
	logic [2:0] internal_sel;
	logic [15:0] channel_sw, pin_pullup_en, pin_drive_en, pin_digital_en;
	logic [49:0] q[$];
	logic [49:0] e;
	logic [47:0] obs;
	logic [31:0] seed = 32'h0000003E;
	int num_errors = 0, checked = 0;
	adc_ref_input_select adc_ref_input_select_inst (.core_clk, .srst, .addr, .wdata, .wr_stb,
		.rd_stb, .rdata, .amp_power_en, .amp_in_pin_sw, .amp_in_bandgap_sw, .amp_gain,
		.ref_supply_sw, .ref_pin_sw, .ref_amp_sw, .bandgap_power_en, .channel_sw,
		.internal_sel, .pin_pullup_en, .pin_drive_en, .pin_digital_en);
	// The clock toggles every 20 ns, half of its 40 ns period.
	always #20 core_clk = ~core_clk;
	////////////////////
	function automatic logic [15:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	// Expected analog controls for the given register contents.
	function automatic logic [47:0] ana(input logic [7:0] c, b, input logic [3:0] s, ch);
		logic [2:0] sel;
		sel = s[3] ? (s[2] ? 3'h0 : 3'h7) :
			(s[1:0] == 2'h0 ? 3'h0 : {1'b0, s[1:0]} + (s[2] ? 3'h3 : 3'h0));
		return {20'h0, c[7], !c[4], c[4], c[1:0], c[3:2] == 2'h0, c[3:2] == 2'h1, c[3], b[0],
			sel, sel == 3'h0 ? 16'h0001 << ch : 16'h0000};
	endfunction
	// Strobes are set for both kinds each time, so back-to-back calls never clash.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		rd_stb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] x);
		q.push_back({2'h0, 32'h0, x});
		addr <= a;
		rd_stb <= 1'b1;
		wr_stb <= 1'b0;
		@(posedge core_clk);
	endtask
	// Outputs settle one edge after the register takes the write.
	task automatic look(input logic [1:0] k, input logic [47:0] x);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		@(posedge core_clk);
		q.push_back({k, x});
		look_stb <= 1'b1;
		@(posedge core_clk);
		look_stb <= 1'b0;
	endtask
	task automatic cmp();
		e = q.pop_front();
		case (e[49:48])
			2'h0: obs = {32'h0, rdata};
			2'h1: obs = {20'h0, amp_power_en, amp_in_pin_sw, amp_in_bandgap_sw, amp_gain,
				ref_supply_sw, ref_pin_sw, ref_amp_sw, bandgap_power_en, internal_sel, channel_sw};
			default: obs = {pin_pullup_en, pin_drive_en, pin_digital_en};
		endcase
		checked++;
		if (obs !== e[47:0]) begin
			num_errors++;
			$display("BAD group %0d exp %h got %h", e[49:48], e[47:0], obs);
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////
	// Monitor takes the oldest note when a read answer or a look falls due.
	always @(posedge core_clk) begin
		rd_d <= rd_stb;
		if (rd_d)
			cmp();
		if (look_stb)
			cmp();
	end
	// Watchdog cuts a hang short well past the expected few hundred cycles.
	initial begin
		repeat (3000) @(posedge core_clk);
		num_errors++;
		finish_test();
	end
	// Main sequence: reset, unmapped access, every source code, pins, reset again.
	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		wr(4'hF, 16'hFFFF);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 16'h0000); // Zero after reset.
		// Reference pins go analog before any reference source is picked.
		wr(4'h4, 16'hFFFF); // Other pin functions off first.
		for (int i = 0; i < 16; i++) begin
			r1 = xs();
			r2 = xs();
			r3 = xs();
			// Bandgap power is set before the amplifier may pick it.
			wr(4'h1, r2); // Bandgap first.
			wr(4'h0, r1);
			wr(4'h2, r3);
			wr(4'h3, {8'h00, i[3:0], r3[7:4]});
			look(2'h1, ana(r1[7:0], r2[7:0], i[3:0], r3[3:0])); // Mux.
			rd(4'h0, r1 & 16'h009F); // Amp reg.
			rd(4'h1, r2 & 16'h0001); // Bandgap reg.
			rd(4'h3, {8'h00, i[3:0], r3[7:4]}); // Source reg.
		end
		repeat (6) begin
			r1 = xs();
			r2 = xs();
			r3 = xs();
			wr(4'h4, r1);
			wr(4'h5, r2);
			wr(4'h6, r3);
			look(2'h2, {r2 & ~r1, r3 & ~r1, ~r1}); // Pins.
		end
		srst <= 1'b1;
		@(posedge core_clk);
		srst <= 1'b0;
		rd(4'h0, 16'h0000); // Cleared.
		look(2'h2, {32'h0, 16'hFFFF}); // Pins free.
		finish_test();
	end
endmodule
`default_nettype wire
